// ===== src/ersc_pkg.sv
// constants and types for the ethernet receive status capture block
package ersc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [31:0] ADDR_RX_FRAME_STATUS = 32'hff800014;
	localparam logic [31:0] ADDR_GEN_CTRL = 32'hff800018;
	localparam logic [31:0] ADDR_GEN_STAT = 32'hff80001c;
	localparam logic [31:0] RX_FRAME_STATUS_RESET = 32'h00000000;
	// ----------------------------------------
	// status word fields
	// ----------------------------------------
	localparam int POS_BYTE_COUNT = 16;
	localparam int POS_CARRIER_EVENT = 15;
	localparam int POS_DATA_VIOLATION = 14;
	localparam int POS_GOOD = 13;
	localparam int POS_BROADCAST = 12;
	localparam int POS_MULTICAST = 11;
	localparam int POS_CRC_ERROR = 10;
	localparam int POS_DRIBBLE = 9;
	localparam int POS_CODE_VIOLATION = 8;
	localparam int POS_TOO_LONG = 7;
	localparam int POS_TOO_SHORT = 6;
	localparam int POS_OVERRUN = 5;
	// ----------------------------------------
	// general control and status fields
	// ----------------------------------------
	localparam int POS_ACCEPT_LONG = 0;
	localparam int POS_ACCEPT_SHORT = 1;
	localparam int POS_DMA_MODE = 2;
	localparam int POS_BUF_COMPLETE = 0;
	localparam int POS_STATUS_READY = 1;
	localparam int POS_FIFO_HAS_DATA = 2;
	localparam logic [2:0] GEN_CTRL_RESET = 3'h0;
	// ----------------------------------------
	// frame limits and line codes
	// ----------------------------------------
	localparam logic [15:0] MAX_FRAME_BYTES = 16'd1518;
	localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;
	localparam logic [3:0] NIB_SFD = 4'hd;
	localparam logic [3:0] NIB_FALSE_CARRIER = 4'he;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	// ----------------------------------------
	// receive sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_PREAMBLE, ST_DATA, ST_DISCARD} ersc_state_type;
endpackage

// ===== src/ersc_rx_status.sv
// ethernet receive status capture: mii receive checks, status register, apb slave
// How it works
// (RL1) status register holds last completed frame; next completion replaces it
// (RL2) loading the status register sets buffer-complete in general status
// (RL3) dma mode: status bits 15..0 go to descriptor status/index field
// (RL4) bits 31..16 give byte count of the next packet in the fifo
// (RL5) dma mode: byte count goes to descriptor buffer length field
// (RL6) bit 15: carrier event seen since previous status, not this packet
// (RL7) bit 14: data violation seen since previous status, not this packet
// (RL8) missing valid preamble and start delimiter counts as data violation
// (RL9) bit 13: error-free packet; raises drain flags until packet drained
// (RL10) bit 12: broadcast packet; drain flags raised so it can be drained
// (RL11) bit 11: multicast packet; drain flags raised so it can be drained
// (RL12) bit 10: crc error; drain flags stay low, packet flushed
// (RL13) bit 9: one to seven dribble bits; flagged, flush per next line
// (RL14) dribble packet counts valid when crc is good
// (RL15) bit 8: rx error during data phase; drain flags low, flush
// (RL16) bit 7: longer than 1518 bytes; drain flags low, flush
// (RL17) long packet accepted only when accept-long enable set
// (RL18) bit 6: shorter than 64 bytes; drain flags low, flush
// (RL19) short packet accepted only when accept-short enable set
// (RL20) bit 5: fifo overrun during frame; drain flags low, flush
// (RL21) all status fields of one frame load in the same cycle
//
// Design decision made here: the APB interface to the registers.
module ersc_rx_status
	import ersc_pkg::*;
(
	input wire logic CLK_SYS, // system clock
	input wire logic NRST, // async reset, active low
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb write
	input wire logic [31:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic RX_CLK, // phy receive clock pin
	input wire logic RX_DV, // phy receive data valid
	input wire logic RX_ER, // phy receive error
	input wire logic [3:0] RXD, // phy receive nibble
	input wire logic FIFO_FULL, // receive fifo full
	input wire logic PKT_DRAINED, // packet emptied from fifo
	output logic FIFO_FLUSH, // pulse: drop bad packet
	output logic STATUS_READY, // status-ready drain flag
	output logic FIFO_HAS_DATA, // fifo-has-data drain flag
	output logic DESC_WRITE, // pulse: descriptor fields valid
	output logic [15:0] DESC_STATUS_INDEX, // descriptor status/index
	output logic [15:0] DESC_LENGTH // descriptor buffer length
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [2:0] clk_sync;
	logic [1:0] dv_sync;
	logic [1:0] er_sync;
	logic [3:0] rxd_s1;
	logic [3:0] rxd_s2;
	logic nib_strobe;
	ersc_state_type state;
	logic [16:0] nib_count;
	logic [31:0] crc;
	logic [31:0] crc_at_byte;
	logic [3:0] low_nib;
	logic bcast_run;
	logic mcast_bit;
	logic code_err;
	logic overrun;
	logic carrier_pend;
	logic violation_pend;
	logic carrier_event;
	logic violation_event;
	logic frame_done;
	logic [15:0] byte_count;
	logic crc_bad;
	logic dribble;
	logic too_long;
	logic too_short;
	logic frame_good;
	logic [31:0] next_status;
	logic [31:0] rx_frame_status;
	logic [2:0] gen_ctrl;
	logic buf_complete;
	logic apb_setup;
	logic apb_write;
	logic mapped;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// advance crc by one nibble, lsb first
	function automatic logic [31:0] crc_nibble(input logic [31:0] c, input logic [3:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// address decode for the error path; the read path decodes PADDR in its own case
	function automatic logic is_mapped(input logic [31:0] a);
		return (a == ADDR_RX_FRAME_STATUS) || (a == ADDR_GEN_CTRL) || (a == ADDR_GEN_STAT);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// two stages per pin, a third on the clock for edge finding
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			clk_sync <= 3'h0;
			dv_sync <= 2'h0;
			er_sync <= 2'h0;
			rxd_s1 <= 4'h0;
			rxd_s2 <= 4'h0;
		end
		else
		begin
			clk_sync <= {clk_sync[1:0], RX_CLK};
			dv_sync <= {dv_sync[0], RX_DV};
			er_sync <= {er_sync[0], RX_ER};
			rxd_s1 <= RXD;
			rxd_s2 <= rxd_s1;
		end
	end

	// take the nibble at the falling link edge, mid-bit
	assign nib_strobe = clk_sync[2] & ~clk_sync[1];

	// ----------------------------------------
	// receive sequencer
	// ----------------------------------------
	assign frame_done = nib_strobe && !dv_sync[1] && state == ST_DATA;
	// false carrier nibble outside a frame
	assign carrier_event = nib_strobe && !dv_sync[1] && er_sync[1] && rxd_s2 == NIB_FALSE_CARRIER; // see (RL6)
	// frame opening without preamble, bad preamble nibble, or valid dropped before the delimiter
	assign violation_event = nib_strobe && ((state == ST_IDLE && dv_sync[1] && rxd_s2 != NIB_PREAMBLE)
		|| (state == ST_PREAMBLE && (dv_sync[1] ? (rxd_s2 != NIB_PREAMBLE && rxd_s2 != NIB_SFD) : 1'b1))); // see (RL8)

	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			state <= ST_IDLE;
		end
		else if (nib_strobe)
		begin
			case (state)
				ST_IDLE:
					if (dv_sync[1])
					begin
						state <= (rxd_s2 == NIB_PREAMBLE) ? ST_PREAMBLE : ST_DISCARD;
					end
				ST_PREAMBLE:
					if (!dv_sync[1])
					begin
						state <= ST_IDLE;
					end
					else if (rxd_s2 == NIB_SFD)
					begin
						state <= ST_DATA;
					end
					else if (rxd_s2 != NIB_PREAMBLE)
					begin
						state <= ST_DISCARD;
					end
				ST_DATA, ST_DISCARD:
					if (!dv_sync[1])
					begin
						state <= ST_IDLE;
					end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// frame checks
	// ----------------------------------------
	// nibble count, crc, address class and error tracking per frame
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			nib_count <= 17'h0;
			crc <= CRC_INIT;
			crc_at_byte <= CRC_INIT;
			low_nib <= 4'h0;
			bcast_run <= 1'b0;
			mcast_bit <= 1'b0;
			code_err <= 1'b0;
			overrun <= 1'b0;
		end
		else if (state != ST_DATA)
		begin
			nib_count <= 17'h0;
			crc <= CRC_INIT;
			crc_at_byte <= CRC_INIT;
			bcast_run <= 1'b1;
			mcast_bit <= 1'b0;
			code_err <= 1'b0;
			overrun <= 1'b0;
		end
		else
		begin
			if (FIFO_FULL)
				overrun <= 1'b1; // see (RL20)
			if (nib_strobe && dv_sync[1])
			begin
				if (nib_count != 17'h1ffff)
					nib_count <= nib_count + 17'h1;
				crc <= crc_nibble(crc, rxd_s2);
				if (er_sync[1])
					code_err <= 1'b1; // see (RL15)
				if (!nib_count[0])
					low_nib <= rxd_s2;
				else
				begin
					// whole byte done: keep crc for dribble handling
					crc_at_byte <= crc_nibble(crc, rxd_s2);
					// destination address is the first six bytes
					if (nib_count < 17'd12 && {rxd_s2, low_nib} != 8'hff)
						bcast_run <= 1'b0; // see (RL10)
					if (nib_count == 17'd1)
						mcast_bit <= low_nib[0]; // see (RL11)
				end
			end
		end
	end

	assign byte_count = (nib_count[16]) ? 16'hffff : nib_count[16:1]; // see (RL4)
	assign dribble = nib_count[0]; // see (RL13)
	// an odd trailing nibble is left out of the crc check
	assign crc_bad = crc_at_byte != CRC_RESIDUE; // see (RL12) (RL14)
	assign too_long = byte_count > MAX_FRAME_BYTES; // see (RL16)
	assign too_short = byte_count < MIN_FRAME_BYTES; // see (RL18)
	assign frame_good = !crc_bad && !code_err && !overrun
		&& (!too_long || gen_ctrl[POS_ACCEPT_LONG]) // see (RL17)
		&& (!too_short || gen_ctrl[POS_ACCEPT_SHORT]); // see (RL19) (RL9)

	// ----------------------------------------
	// events since the previous status
	// ----------------------------------------
	// a new event in the load cycle is kept for the next status
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			carrier_pend <= 1'b0;
			violation_pend <= 1'b0;
		end
		else
		begin
			carrier_pend <= (carrier_pend && !frame_done) || carrier_event; // see (RL6)
			violation_pend <= (violation_pend && !frame_done) || violation_event; // see (RL7)
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	always_comb
	begin
		next_status = 32'h0;
		next_status[31:POS_BYTE_COUNT] = byte_count;
		next_status[POS_CARRIER_EVENT] = carrier_pend;
		next_status[POS_DATA_VIOLATION] = violation_pend;
		next_status[POS_GOOD] = frame_good;
		next_status[POS_BROADCAST] = bcast_run && !too_short;
		next_status[POS_MULTICAST] = mcast_bit && !bcast_run;
		next_status[POS_CRC_ERROR] = crc_bad;
		next_status[POS_DRIBBLE] = dribble;
		next_status[POS_CODE_VIOLATION] = code_err;
		next_status[POS_TOO_LONG] = too_long;
		next_status[POS_TOO_SHORT] = too_short;
		next_status[POS_OVERRUN] = overrun;
	end

	// whole word loads in one cycle at frame end
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			rx_frame_status <= RX_FRAME_STATUS_RESET;
		end
		else if (frame_done)
		begin
			rx_frame_status <= next_status; // see (RL1) (RL21)
		end
	end

	// ----------------------------------------
	// drain, flush and descriptor outputs
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			STATUS_READY <= 1'b0;
			FIFO_HAS_DATA <= 1'b0;
			FIFO_FLUSH <= 1'b0;
			DESC_WRITE <= 1'b0;
			DESC_STATUS_INDEX <= 16'h0;
			DESC_LENGTH <= 16'h0;
		end
		else
		begin
			// good frame raises the flags; drained clears, set wins
			if (frame_done && frame_good)
			begin
				STATUS_READY <= 1'b1; // see (RL9) (RL10) (RL11)
				FIFO_HAS_DATA <= 1'b1;
			end
			else if (PKT_DRAINED)
			begin
				STATUS_READY <= 1'b0;
				FIFO_HAS_DATA <= 1'b0;
			end
			FIFO_FLUSH <= frame_done && !frame_good; // see (RL12) (RL15) (RL16) (RL18) (RL20)
			DESC_WRITE <= frame_done && gen_ctrl[POS_DMA_MODE];
			if (frame_done && gen_ctrl[POS_DMA_MODE])
			begin
				DESC_STATUS_INDEX <= next_status[15:0]; // see (RL3)
				DESC_LENGTH <= byte_count; // see (RL5)
			end
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign apb_setup = PSEL && !PENABLE;
	assign apb_write = PSEL && PENABLE && PREADY && PWRITE;
	assign mapped = is_mapped(PADDR);

	// no wait state: ready and data registered in the setup cycle
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
		end
		else
		begin
			PREADY <= apb_setup;
			PSLVERR <= apb_setup && !mapped;
			PRDATA <= 32'h0;
			if (apb_setup && !PWRITE)
			begin
				case (PADDR)
					ADDR_RX_FRAME_STATUS: PRDATA <= rx_frame_status;
					ADDR_GEN_CTRL: PRDATA <= {29'h0, gen_ctrl};
					ADDR_GEN_STAT: PRDATA <= {29'h0, FIFO_HAS_DATA, STATUS_READY, buf_complete};
					default: PRDATA <= 32'h0;
				endcase
			end
		end
	end

	// control register
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			gen_ctrl <= GEN_CTRL_RESET;
		end
		else if (apb_write && PADDR == ADDR_GEN_CTRL)
		begin
			gen_ctrl <= PWDATA[2:0];
		end
	end

	// buffer complete: set on status load, write one to clear, set wins
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			buf_complete <= 1'b0;
		end
		else if (frame_done)
		begin
			buf_complete <= 1'b1; // see (RL2)
		end
		else if (apb_write && PADDR == ADDR_GEN_STAT && PWDATA[POS_BUF_COMPLETE])
		begin
			buf_complete <= 1'b0;
		end
	end
endmodule

// ===== tb/ersc_checker.sv
// port-level assertions for the receive status capture block
module ersc_chk (
	input wire logic CLK_SYS, // clock
	input wire logic NRST, // reset, low
	input wire logic PSEL, // select
	input wire logic PENABLE, // access
	input wire logic PREADY, // ready
	input wire logic [31:0] PRDATA, // read data
	input wire logic PSLVERR, // error
	input wire logic PKT_DRAINED, // drained
	input wire logic FIFO_FLUSH, // flush pulse
	input wire logic STATUS_READY, // drain flag
	input wire logic FIFO_HAS_DATA, // drain flag
	input wire logic DESC_WRITE, // desc pulse
	input wire logic [15:0] DESC_STATUS_INDEX // desc status
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	// -----------------------------
	// bus steps
	// -----------------------------
	sequence apb_setup;
		PSEL && !PENABLE;
	endsequence
	sequence apb_answer;
		PSEL && PENABLE && PREADY ##1 !PREADY;
	endsequence
	chk_ready_after_setup: assert property (apb_setup |=> apb_answer)
		else $error("no single ready after setup");
	chk_error_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	chk_read_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside access");
	// -----------------------------
	// frame results
	// -----------------------------
	chk_flags_paired: assert property (STATUS_READY == FIFO_HAS_DATA)
		else $error("drain flags differ");
	chk_flush_one_cycle: assert property (FIFO_FLUSH |=> !FIFO_FLUSH)
		else $error("flush longer than one cycle");
	chk_flush_or_good: assert property (DESC_WRITE && DESC_STATUS_INDEX[7:6] == 2'h0 |-> FIFO_FLUSH != DESC_STATUS_INDEX[13])
		else $error("flush does not match good bit");
	chk_good_raises_flags: assert property (DESC_WRITE && DESC_STATUS_INDEX[13] |-> STATUS_READY)
		else $error("good frame without drain flags");
	chk_drain_clears: assert property ($fell(STATUS_READY) |-> $past(PKT_DRAINED))
		else $error("drain flag fell without drain");
	chk_desc_only_on_write: assert property ($changed(DESC_STATUS_INDEX) |-> DESC_WRITE)
		else $error("descriptor changed without write");
	chk_desc_one_cycle: assert property (DESC_WRITE |=> !DESC_WRITE)
		else $error("descriptor write longer than one cycle");
endmodule
bind ersc_rx_status ersc_chk u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .PKT_DRAINED(PKT_DRAINED), .FIFO_FLUSH(FIFO_FLUSH),
	.STATUS_READY(STATUS_READY), .FIFO_HAS_DATA(FIFO_HAS_DATA), .DESC_WRITE(DESC_WRITE),
	.DESC_STATUS_INDEX(DESC_STATUS_INDEX));

// ===== tb/ersc_phy_model.sv
// receive side phy model: nibble stream with preamble, delimiter and events
module ersc_phy_model
	import ersc_pkg::*;
(
	output logic RX_CLK, // receive clock, still between frames
	output logic RX_DV, // data valid
	output logic RX_ER, // receive error
	output logic [3:0] RXD // nibble
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {RX_CLK, RX_DV, RX_ER, RXD} = 7'h40;
	// one nibble, sampled by the block at the falling clock edge
	task nib(input logic dv, input logic er, input logic [3:0] d);
		{RX_DV, RX_ER, RXD} = {dv, er, d};
		#100 RX_CLK = 1'b0;
		#100 RX_CLK = 1'b1;
	endtask
	// idle nibbles carry a changing pattern, never a stale value
	task idle();
		repeat (3) nib(1'b0, 1'b0, ~RXD);
	endtask
	task send(input logic [7:0] q[$], input int drib, input int er_at);
		repeat (15) nib(1'b1, 1'b0, NIB_PREAMBLE);
		nib(1'b1, 1'b0, NIB_SFD);
		for (int i = 0; i < 2 * q.size(); i++)
			nib(1'b1, logic'(i == er_at), i[0] ? q[i / 2][7:4] : q[i / 2][3:0]);
		if (drib != 0)
			nib(1'b1, 1'b0, 4'h3);
		idle();
	endtask
	// broken preamble, dropped before the delimiter
	task bad_preamble();
		nib(1'b1, 1'b0, NIB_PREAMBLE);
		nib(1'b1, 1'b0, 4'h4);
		idle();
	endtask
	task carrier();
		nib(1'b0, 1'b1, NIB_FALSE_CARRIER);
		idle();
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the receive status capture block
module testbench
	import ersc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, nrst, psel, penable, pwrite, fifo_full, pkt_drained, err;
	logic [31:0] paddr, pwdata, rd;
	logic [31:0] prdata;
	logic pready, pslverr, fifo_flush, status_ready, fifo_has_data, desc_write, rx_clk, rx_dv, rx_er;
	logic [15:0] desc_status_index, desc_length;
	logic [3:0] rxd;
	logic [7:0] fr[$];
	int failures, samples_checked, flushes, descs;
	ersc_rx_status dut (.CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_CLK(rx_clk),
		.RX_DV(rx_dv), .RX_ER(rx_er), .RXD(rxd), .FIFO_FULL(fifo_full), .PKT_DRAINED(pkt_drained),
		.FIFO_FLUSH(fifo_flush), .STATUS_READY(status_ready), .FIFO_HAS_DATA(fifo_has_data),
		.DESC_WRITE(desc_write), .DESC_STATUS_INDEX(desc_status_index), .DESC_LENGTH(desc_length));
	ersc_phy_model phy (.RX_CLK(rx_clk), .RX_DV(rx_dv), .RX_ER(rx_er), .RXD(rxd));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// count one-cycle pulses
	always @(posedge clk_sys)
	begin
		if (fifo_flush === 1'b1)
			flushes++;
		if (desc_write === 1'b1)
			descs++;
	end
	// -----------------------------
	// shared tasks
	// -----------------------------
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// wait for ready; only the watchdog ends a hang
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] b(int p);
		return 32'h1 << p;
	endfunction
	// frame of n bytes incl. fcs, destination bytes all da
	task frame(input logic [7:0] da, input int n, input logic bad_fcs);
		logic [31:0] c;
		fr = {};
		c = CRC_INIT;
		for (int i = 0; i < n - 4; i++)
		begin
			fr.push_back(i < 6 ? da : i[7:0]);
			c = c ^ {24'h0, fr[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		c = ~c ^ {31'h0, bad_fcs};
		for (int k = 0; k < 4; k++)
			fr.push_back(c[8 * k +: 8]);
	endtask
	// send, then judge status, descriptor, flush, flags and drain
	task run(input int drib, input int er_at, input logic [31:0] exp, input int fl, input int flg);
		int f0, d0;
		f0 = flushes;
		d0 = descs;
		phy.send(fr, drib, er_at);
		chk("flush count", 32'(fl), 32'(flushes - f0));
		chk("descriptor writes", 32'h1, 32'(descs - d0));
		if (flg < 2)
		begin
			apb(1'b0, ADDR_RX_FRAME_STATUS, 32'h0);
			chk("status", exp, rd);
			chk("desc status", {16'h0, exp[15:0]}, {16'h0, desc_status_index});
			chk("desc length", {16'h0, exp[31:16]}, {16'h0, desc_length});
			chk("drain flags", {30'h0, {2{flg[0]}}}, {30'h0, status_ready, fifo_has_data});
		end
		apb(1'b0, ADDR_GEN_STAT, 32'h0);
		chk("buffer complete", 32'h1, {31'h0, rd[POS_BUF_COMPLETE]});
		apb(1'b1, ADDR_GEN_STAT, 32'h1);
		pkt_drained <= 1'b1;
		@(posedge clk_sys);
		pkt_drained <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("flags after drain", 32'h0, {30'h0, status_ready, fifo_has_data});
	endtask
	// -----------------------------
	// scenarios
	// -----------------------------
	task t_regs();
		apb(1'b1, ADDR_RX_FRAME_STATUS, 32'hffffffff);
		apb(1'b0, ADDR_RX_FRAME_STATUS, 32'h0);
		chk("status reset", RX_FRAME_STATUS_RESET, rd);
		apb(1'b0, 32'hff800020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, ADDR_GEN_CTRL, b(POS_DMA_MODE));
		apb(1'b0, ADDR_GEN_CTRL, 32'h0);
		chk("control", b(POS_DMA_MODE), rd);
	endtask
	task t_events_crc();
		phy.bad_preamble();
		phy.carrier();
		frame(8'h01, 80, 1'b1);
		run(0, -1, {16'h0050, 16'h0} | b(POS_CARRIER_EVENT) | b(POS_DATA_VIOLATION) | b(POS_MULTICAST)
			| b(POS_CRC_ERROR), 1, 0);
	endtask
	task t_cv_overrun();
		frame(8'h02, 64, 1'b0);
		fifo_full <= 1'b1;
		run(0, 20, {16'h0040, 16'h0} | b(POS_CODE_VIOLATION) | b(POS_OVERRUN), 1, 0);
		fifo_full <= 1'b0;
	endtask
	task t_short();
		frame(8'h02, 63, 1'b0);
		run(0, -1, {16'h003f, 16'h0} | b(POS_TOO_SHORT), 1, 0);
		apb(1'b1, ADDR_GEN_CTRL, b(POS_DMA_MODE) | b(POS_ACCEPT_SHORT));
		run(0, -1, {16'h003f, 16'h0} | b(POS_TOO_SHORT) | b(POS_GOOD), 0, 1);
	endtask
	task t_long();
		frame(8'h02, 1519, 1'b0);
		run(0, -1, {16'h05ef, 16'h0} | b(POS_TOO_LONG), 1, 0);
		apb(1'b1, ADDR_GEN_CTRL, b(POS_DMA_MODE) | b(POS_ACCEPT_LONG));
		run(0, -1, {16'h05ef, 16'h0} | b(POS_TOO_LONG) | b(POS_GOOD), 0, 1);
	endtask
	task t_broadcast();
		frame(8'hff, 64, 1'b0);
		run(0, -1, {16'h0040, 16'h0} | b(POS_GOOD) | b(POS_BROADCAST), 0, 1);
	endtask
	task t_dribble();
		frame(8'h02, 64, 1'b0);
		run(1, -1, {16'h0040, 16'h0} | b(POS_GOOD) | b(POS_DRIBBLE), 0, 1);
	endtask
	// dma mode off: frame completes with no descriptor write
	task t_no_dma();
		int d0;
		apb(1'b1, ADDR_GEN_CTRL, 32'h0);
		d0 = descs;
		frame(8'h02, 64, 1'b0);
		phy.send(fr, 0, -1);
		chk("descriptor writes", 32'h0, 32'(descs - d0));
		chk("drain flags", 32'h3, {30'h0, status_ready, fifo_has_data});
	endtask
	task close_out();
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		{psel, penable, pwrite, fifo_full, pkt_drained, nrst} = 6'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		t_regs();
		t_broadcast();
		t_events_crc();
		t_dribble();
		t_cv_overrun();
		t_short();
		t_long();
		t_no_dma();
		close_out();
	end
	initial
	begin
		#2000000;
		failures++;
		close_out();
	end
endmodule
